// >>> ctfm_pkg.sv
`default_nettype none
package ctfm_pkg;
  // command codes, seven bits
  localparam logic [6:0] CMD_REQA = 7'h26;
  localparam logic [6:0] CMD_WUPA = 7'h52;
  localparam logic [6:0] CMD_RID = 7'h78;
  localparam logic [6:0] CMD_READ_ALL_CMD = 7'h00;
  localparam logic [6:0] CMD_READ = 7'h01;
  localparam logic [6:0] CMD_WRE = 7'h53;
  localparam logic [6:0] CMD_WRNE = 7'h1a;
  // memory map
  localparam logic [6:0] MEM_BYTES = 7'h78;
  localparam logic [3:0] BLK_UID = 4'h0;
  localparam logic [3:0] BLK_RSV = 4'hd;
  localparam logic [3:0] BLK_LOCK = 4'he;
  localparam logic [6:0] LOCK_LO_IDX = 7'h70;
  localparam logic [6:0] LOCK_HI_IDX = 7'h71;
  // frame bit counts
  localparam logic [3:0] SHORT_BITS = 4'h7;
  localparam logic [3:0] OPER_BITS = 4'h8;
  localparam logic [3:0] PAR_POS = 4'h8;
  localparam logic [3:0] OPER_LAST = 4'h7;
  localparam logic [3:0] OPER_DATA = 4'h6;
  // response lengths in bytes
  localparam logic [6:0] LEN_ATQA = 7'h02;
  localparam logic [6:0] LEN_RID = 7'h08;
  localparam logic [6:0] LEN_READ_ALL_CMD = 7'h7c;
  localparam logic [6:0] LEN_RW = 7'h04;
  localparam logic [6:0] HDR_BYTES = 7'h02;
  // crc, reflected ccitt form
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  // arbitrary identity values
  localparam logic [7:0] HDR_ID_DEF = 8'h5a;
  localparam logic [3:0] HDR_FAMILY_DEF = 4'h5;
  // reader answer timeout, cycles
  localparam logic [11:0] RSP_WAIT_CYC = 12'h7d0;

  typedef enum logic [2:0] {RSP_ATQA, RSP_RID, RSP_READ_ALL_CMD, RSP_READ, RSP_WRITE} ctfm_rsp_t;

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_upd
endpackage : ctfm_pkg
`default_nettype wire

// >>> ctfm_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ctfm_link_if;
  // reader to tag, one bit per cycle
  logic r_sof;
  logic r_bit_vld;
  logic r_bit;
  logic r_eof;
  // tag to reader
  logic t_sof;
  logic t_bit_vld;
  logic t_bit;
  logic t_eof;
  modport tag_end (input r_sof, r_bit_vld, r_bit, r_eof, output t_sof, t_bit_vld, t_bit, t_eof);
  modport reader_end (output r_sof, r_bit_vld, r_bit, r_eof, input t_sof, t_bit_vld, t_bit, t_eof);
endinterface : ctfm_link_if
`default_nettype wire

// >>> ctfm_tag.sv
// Contract
// - fixed two-byte header, first byte identifies
// - reader ignores second header byte
// - reader checks header family nibble only
// - fifteen blocks of eight bytes, lockable
// - block zero holds uid, always locked
// - blocks one to C user data
// - block E low bytes hold lock bits
// - block E high bytes are otp bits
// - header bytes inserted in identity, read-all
// - idle after reset, ready on REQA/WUPA
// - collision handling uses four low uid bytes
// - reader sends short frame then operands
// - every data set in its own frame
// - only start-of-frame starts; command is seven bits
// - operand frames eight bits, lsb first
// - response is one contiguous frame
// - response bytes sent lsb first
// - odd parity after each response byte
// - end-of-frame right after last parity
// - two-byte crc except REQA/WUPA/ATQA
// - crc mismatch abandons, back to ready
// - uid echo mismatch stops, stays ready
// - command codes 78h 00h 01h 53h 1Ah
`timescale 1ns/1ns
`default_nettype none
module ctfm_tag #(
  // arbitrary identity values
  parameter logic [7:0] HDR_ID = ctfm_pkg::HDR_ID_DEF,
  parameter logic [7:0] HDR_RSV = 8'h00,
  parameter logic [55:0] UID = 56'h66554433221100,
  parameter logic [15:0] ATQA = 16'h000c
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link
  ctfm_link_if.tag_end lnk,
  // status
  output logic tag_ready,
  output logic cmd_done,
  output logic cmd_fail
);
  typedef enum logic [1:0] {ST_IDLE, ST_READY, ST_OPER, ST_TX} ctfm_tst_t;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] mem_q [120];
  logic mem_we;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;
  ctfm_tst_t st_q, st_d;
  logic [6:0] cmd_q, cmd_d;
  logic [7:0] ops_q [8];
  logic [7:0] ops_d [8];
  logic [3:0] opc_q, opc_d;
  logic [15:0] crc_q, crc_d;
  ctfm_pkg::ctfm_rsp_t rsp_q, rsp_d;
  logic [6:0] len_q, len_d, idx_q, idx_d;
  logic [3:0] bit_q, bit_d;
  logic sofp_q, sofp_d;
  logic [15:0] tcrc_q, tcrc_d;
  logic o_sof_q, o_sof_d, o_vld_q, o_vld_d, o_bit_q, o_bit_d, o_eof_q, o_eof_d;
  logic done_q, done_d, fail_q, fail_d;
  logic rx_act_q, rx_act_d;
  logic [3:0] rx_cnt_q, rx_cnt_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic fr_short, fr_oper;

  ////////////////////////////////////////////////////////////////////////////
  // receive framing
  always_comb begin
    rx_act_d = rx_act_q;
    rx_cnt_d = rx_cnt_q;
    rx_sh_d = rx_sh_q;
    fr_short = 1'b0;
    fr_oper = 1'b0;
    if (lnk.r_sof) begin
      rx_act_d = 1'b1;
      rx_cnt_d = 4'h0;
    end else if (rx_act_q && lnk.r_bit_vld) begin
      rx_sh_d = {lnk.r_bit, rx_sh_q[7:1]};
      if (rx_cnt_q != 4'hf) begin
        rx_cnt_d = rx_cnt_q + 4'h1;
      end
    end else if (rx_act_q && lnk.r_eof) begin
      rx_act_d = 1'b0;
      fr_short = (rx_cnt_q == ctfm_pkg::SHORT_BITS);
      fr_oper = (rx_cnt_q == ctfm_pkg::OPER_BITS);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 8'h00;
    end else begin
      rx_act_q <= rx_act_d;
      rx_cnt_q <= rx_cnt_d;
      rx_sh_q <= rx_sh_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response byte source
  logic [7:0] cur;
  logic [15:0] lockw;
  logic crc_zone;
  logic [6:0] add;
  logic [3:0] blk;
  logic add_ok;
  always_comb begin
    add = ops_q[0][6:0];
    blk = add[6:3];
    add_ok = add < ctfm_pkg::MEM_BYTES;
    // lock bits in block E low bytes
    lockw = {mem_q[ctfm_pkg::LOCK_HI_IDX], mem_q[ctfm_pkg::LOCK_LO_IDX]};
    crc_zone = (rsp_q != ctfm_pkg::RSP_ATQA) && (idx_q >= len_q - 7'h02);
    cur = 8'h00;
    if (crc_zone) begin
      cur = (idx_q == len_q - 7'h02) ? ~tcrc_q[7:0] : ~tcrc_q[15:8];
    end else begin
      unique case (rsp_q)
        ctfm_pkg::RSP_ATQA: cur = (idx_q == 7'h00) ? ATQA[7:0] : ATQA[15:8];
        ctfm_pkg::RSP_RID, ctfm_pkg::RSP_READ_ALL_CMD: begin
          if (idx_q == 7'h00) begin
            cur = HDR_ID;
          end else if (idx_q == 7'h01) begin
            cur = HDR_RSV;
          end else begin
            cur = mem_q[idx_q - ctfm_pkg::HDR_BYTES];
          end
        end
        ctfm_pkg::RSP_READ, ctfm_pkg::RSP_WRITE: begin
          if (idx_q == 7'h00) begin
            cur = ops_q[0];
          end else if (add_ok) begin
            cur = mem_q[add];
          end
        end
        default: cur = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command and transmit sequencing
  logic [7:0] byte_in;
  logic wr_ok;
  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    ops_d = ops_q;
    opc_d = opc_q;
    crc_d = crc_q;
    rsp_d = rsp_q;
    len_d = len_q;
    idx_d = idx_q;
    bit_d = bit_q;
    sofp_d = sofp_q;
    tcrc_d = tcrc_q;
    o_sof_d = 1'b0;
    o_vld_d = 1'b0;
    o_bit_d = 1'b0;
    o_eof_d = 1'b0;
    done_d = 1'b0;
    fail_d = 1'b0;
    mem_we = 1'b0;
    mem_wa = add;
    mem_wd = 8'h00;
    byte_in = {1'b0, rx_sh_q[7:1]};
    wr_ok = add_ok && (blk != ctfm_pkg::BLK_UID) && (blk != ctfm_pkg::BLK_RSV) && !lockw[blk];
    unique case (st_q)
      ST_IDLE, ST_READY, ST_OPER: begin
        if (fr_short) begin
          if (rx_sh_q[7:1] == ctfm_pkg::CMD_REQA || rx_sh_q[7:1] == ctfm_pkg::CMD_WUPA) begin
            st_d = ST_TX;
            rsp_d = ctfm_pkg::RSP_ATQA;
            len_d = ctfm_pkg::LEN_ATQA;
            idx_d = 7'h00;
            bit_d = 4'h0;
            sofp_d = 1'b1;
          end else if (st_q != ST_IDLE) begin
            st_d = ST_READY;
            if (rx_sh_q[7:1] == ctfm_pkg::CMD_RID || rx_sh_q[7:1] == ctfm_pkg::CMD_READ_ALL_CMD ||
                rx_sh_q[7:1] == ctfm_pkg::CMD_READ || rx_sh_q[7:1] == ctfm_pkg::CMD_WRE ||
                rx_sh_q[7:1] == ctfm_pkg::CMD_WRNE) begin
              st_d = ST_OPER;
              cmd_d = rx_sh_q[7:1];
              opc_d = 4'h0;
              crc_d = ctfm_pkg::crc_upd(ctfm_pkg::CRC_INIT, byte_in);
            end
          end
        end else if (fr_oper && st_q == ST_OPER) begin
          ops_d[opc_q[2:0]] = rx_sh_q;
          opc_d = opc_q + 4'h1;
          if (opc_q < ctfm_pkg::OPER_DATA) begin
            crc_d = ctfm_pkg::crc_upd(crc_q, rx_sh_q);
          end
          if (opc_q == ctfm_pkg::OPER_LAST) begin
            st_d = ST_READY;
            fail_d = 1'b1;
            if ({rx_sh_q, ops_q[6]} == ~crc_q) begin
              if (cmd_q == ctfm_pkg::CMD_RID ||
                  {ops_q[5], ops_q[4], ops_q[3], ops_q[2]} == UID[31:0]) begin
                fail_d = 1'b0;
                st_d = ST_TX;
                idx_d = 7'h00;
                bit_d = 4'h0;
                sofp_d = 1'b1;
                tcrc_d = ctfm_pkg::CRC_INIT;
                len_d = ctfm_pkg::LEN_RW;
                if (cmd_q == ctfm_pkg::CMD_RID) begin
                  rsp_d = ctfm_pkg::RSP_RID;
                  len_d = ctfm_pkg::LEN_RID;
                end else if (cmd_q == ctfm_pkg::CMD_READ_ALL_CMD) begin
                  rsp_d = ctfm_pkg::RSP_READ_ALL_CMD;
                  len_d = ctfm_pkg::LEN_READ_ALL_CMD;
                end else if (cmd_q == ctfm_pkg::CMD_READ) begin
                  rsp_d = ctfm_pkg::RSP_READ;
                end else begin
                  rsp_d = ctfm_pkg::RSP_WRITE;
                  mem_we = wr_ok;
                  // block E bits only ever set
                  if (blk == ctfm_pkg::BLK_LOCK || cmd_q == ctfm_pkg::CMD_WRNE) begin
                    mem_wd = mem_q[add] | ops_q[1];
                  end else begin
                    mem_wd = ops_q[1];
                  end
                end
              end
            end
          end
        end
      end
      ST_TX: begin
        if (sofp_q) begin
          o_sof_d = 1'b1;
          sofp_d = 1'b0;
        end else if (idx_q == len_q) begin
          o_eof_d = 1'b1;
          done_d = 1'b1;
          st_d = ST_READY;
        end else begin
          o_vld_d = 1'b1;
          if (bit_q == ctfm_pkg::PAR_POS) begin
            o_bit_d = ~^cur;
            bit_d = 4'h0;
            idx_d = idx_q + 7'h01;
            if (!crc_zone) begin
              tcrc_d = ctfm_pkg::crc_upd(tcrc_q, cur);
            end
          end else begin
            o_bit_d = cur[bit_q[2:0]];
            bit_d = bit_q + 4'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      cmd_q <= 7'h00;
      opc_q <= 4'h0;
      crc_q <= ctfm_pkg::CRC_INIT;
      rsp_q <= ctfm_pkg::RSP_ATQA;
      len_q <= 7'h00;
      idx_q <= 7'h00;
      bit_q <= 4'h0;
      sofp_q <= 1'b0;
      tcrc_q <= ctfm_pkg::CRC_INIT;
      {o_sof_q, o_vld_q, o_bit_q, o_eof_q, done_q, fail_q} <= 6'h00;
      for (int i = 0; i < 8; i++) begin
        ops_q[i] <= 8'h00;
      end
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      ops_q <= ops_d;
      opc_q <= opc_d;
      crc_q <= crc_d;
      rsp_q <= rsp_d;
      len_q <= len_d;
      idx_q <= idx_d;
      bit_q <= bit_d;
      sofp_q <= sofp_d;
      tcrc_q <= tcrc_d;
      {o_sof_q, o_vld_q, o_bit_q, o_eof_q} <= {o_sof_d, o_vld_d, o_bit_d, o_eof_d};
      {done_q, fail_q} <= {done_d, fail_d};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array image; reset stands in for the nonvolatile contents
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < 120; i++) begin
        // uid in block zero bytes 0..6
        mem_q[i] <= (i < 7) ? UID[8*i +: 8] : 8'h00;
      end
    end else if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  assign lnk.t_sof = o_sof_q;
  assign lnk.t_bit_vld = o_vld_q;
  assign lnk.t_bit = o_bit_q;
  assign lnk.t_eof = o_eof_q;
  assign tag_ready = (st_q != ST_IDLE);
  assign cmd_done = done_q;
  assign cmd_fail = fail_q;
endmodule : ctfm_tag
`default_nettype wire

// >>> ctfm_reader.sv
`timescale 1ns/1ns
`default_nettype none
module ctfm_reader #(
  parameter logic [3:0] HDR_FAMILY = ctfm_pkg::HDR_FAMILY_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link
  ctfm_link_if.reader_end lnk,
  // request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [6:0] req_code,
  input wire logic [7:0] req_add,
  input wire logic [7:0] req_dat,
  input wire logic [31:0] req_uid,
  // answer
  output logic rsp_vld,
  output logic [7:0] rsp_byte,
  output logic rsp_done,
  output logic rsp_err,
  output logic rsp_family_ok
);
  typedef enum logic [2:0] {R_IDLE, R_SOF, R_BITS, R_EOF, R_WAIT} ctfm_rst_t;

  ////////////////////////////////////////////////////////////////////////////
  ctfm_rst_t st_q, st_d;
  logic [6:0] code_q, code_d;
  logic [7:0] add_q, add_d, dat_q, dat_d;
  logic [31:0] uid_q, uid_d;
  logic [3:0] fr_q, fr_d, bit_q, bit_d;
  logic [15:0] crc_q, crc_d;
  logic [11:0] wait_q, wait_d;
  logic o_sof_q, o_sof_d, o_vld_q, o_vld_d, o_bit_q, o_bit_d, o_eof_q, o_eof_d;
  logic [8:0] sh_q, sh_d;
  logic [3:0] rc_q, rc_d;
  logic [6:0] ri_q, ri_d;
  logic [7:0] b1_q, b1_d, b2_q, b2_d;
  logic [15:0] rcrc_q, rcrc_d;
  logic perr_q, perr_d, fam_q, fam_d;
  logic vld_q, vld_d, done_q, done_d, err_q, err_d;
  logic [7:0] byte_q, byte_d;
  logic short_only;
  logic [7:0] fbyte;
  logic [8:0] full;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    short_only = (code_q == ctfm_pkg::CMD_REQA) || (code_q == ctfm_pkg::CMD_WUPA);
    unique case (fr_q)
      4'h0: fbyte = {1'b0, code_q};
      4'h1: fbyte = (code_q == ctfm_pkg::CMD_RID || code_q == ctfm_pkg::CMD_READ_ALL_CMD) ? 8'h00 : add_q;
      4'h2: fbyte = (code_q == ctfm_pkg::CMD_WRE || code_q == ctfm_pkg::CMD_WRNE) ? dat_q : 8'h00;
      4'h3, 4'h4, 4'h5, 4'h6: begin
        fbyte = (code_q == ctfm_pkg::CMD_RID) ? 8'h00 : uid_q[8*(fr_q - 4'h3) +: 8];
      end
      4'h7: fbyte = ~crc_q[7:0];
      default: fbyte = ~crc_q[15:8];
    endcase
  end

  always_comb begin
    st_d = st_q;
    code_d = code_q;
    add_d = add_q;
    dat_d = dat_q;
    uid_d = uid_q;
    fr_d = fr_q;
    bit_d = bit_q;
    crc_d = crc_q;
    wait_d = wait_q;
    o_sof_d = 1'b0;
    o_vld_d = 1'b0;
    o_bit_d = 1'b0;
    o_eof_d = 1'b0;
    unique case (st_q)
      R_IDLE: if (req_valid) begin
        {code_d, add_d, dat_d, uid_d} = {req_code, req_add, req_dat, req_uid};
        fr_d = 4'h0;
        crc_d = ctfm_pkg::CRC_INIT;
        st_d = R_SOF;
      end
      R_SOF: begin
        // each data set in its own frame
        o_sof_d = 1'b1;
        bit_d = 4'h0;
        st_d = R_BITS;
      end
      R_BITS: begin
        o_vld_d = 1'b1;
        o_bit_d = fbyte[bit_q[2:0]];
        bit_d = bit_q + 4'h1;
        if (bit_d == ((fr_q == 4'h0) ? ctfm_pkg::SHORT_BITS : ctfm_pkg::OPER_BITS)) begin
          st_d = R_EOF;
        end
      end
      R_EOF: begin
        o_eof_d = 1'b1;
        if (fr_q < ctfm_pkg::OPER_LAST) begin
          crc_d = ctfm_pkg::crc_upd(crc_q, fbyte);
        end
        fr_d = fr_q + 4'h1;
        wait_d = 12'h000;
        st_d = (short_only || fr_q == ctfm_pkg::OPER_BITS) ? R_WAIT : R_SOF;
      end
      R_WAIT: begin
        wait_d = wait_q + 12'h001;
        if (lnk.t_eof || wait_q == ctfm_pkg::RSP_WAIT_CYC) begin
          st_d = R_IDLE;
        end
      end
      default: st_d = R_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer reception
  always_comb begin
    sh_d = sh_q;
    rc_d = rc_q;
    ri_d = ri_q;
    b1_d = b1_q;
    b2_d = b2_q;
    rcrc_d = rcrc_q;
    perr_d = perr_q;
    fam_d = fam_q;
    vld_d = 1'b0;
    done_d = 1'b0;
    err_d = err_q;
    byte_d = byte_q;
    full = {lnk.t_bit, sh_q[8:1]};
    if (lnk.t_sof) begin
      {rc_d, ri_d, perr_d, fam_d} = {4'h0, 7'h00, 1'b0, 1'b0};
      rcrc_d = ctfm_pkg::CRC_INIT;
    end else if (lnk.t_bit_vld) begin
      sh_d = full;
      rc_d = rc_q + 4'h1;
      if (rc_q == ctfm_pkg::PAR_POS) begin
        rc_d = 4'h0;
        vld_d = 1'b1;
        byte_d = full[7:0];
        if (!(^full)) begin
          perr_d = 1'b1;
        end
        // family nibble only, reserved byte ignored
        if (ri_q == 7'h00) begin
          fam_d = (full[7:4] == HDR_FAMILY) &&
                  (code_q == ctfm_pkg::CMD_RID || code_q == ctfm_pkg::CMD_READ_ALL_CMD);
        end
        if (ri_q >= ctfm_pkg::HDR_BYTES) begin
          rcrc_d = ctfm_pkg::crc_upd(rcrc_q, b2_q);
        end
        b2_d = b1_q;
        b1_d = full[7:0];
        ri_d = ri_q + 7'h01;
      end
    end
    if (st_q == R_WAIT && (lnk.t_eof || wait_q == ctfm_pkg::RSP_WAIT_CYC)) begin
      done_d = 1'b1;
      err_d = !lnk.t_eof || perr_q || (rc_q != 4'h0) ||
              (!short_only && {b1_q, b2_q} != ~rcrc_q);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= R_IDLE;
      {code_q, add_q, dat_q, uid_q} <= 55'h0;
      {fr_q, bit_q, crc_q, wait_q} <= 36'h0;
      {o_sof_q, o_vld_q, o_bit_q, o_eof_q} <= 4'h0;
      {sh_q, rc_q, ri_q, b1_q, b2_q, rcrc_q} <= 52'h0;
      {perr_q, fam_q, vld_q, done_q, err_q, byte_q} <= 13'h0;
    end else begin
      st_q <= st_d;
      {code_q, add_q, dat_q, uid_q} <= {code_d, add_d, dat_d, uid_d};
      {fr_q, bit_q, crc_q, wait_q} <= {fr_d, bit_d, crc_d, wait_d};
      {o_sof_q, o_vld_q, o_bit_q, o_eof_q} <= {o_sof_d, o_vld_d, o_bit_d, o_eof_d};
      {sh_q, rc_q, ri_q, b1_q, b2_q, rcrc_q} <= {sh_d, rc_d, ri_d, b1_d, b2_d, rcrc_d};
      {perr_q, fam_q, vld_q, done_q, err_q, byte_q} <= {perr_d, fam_d, vld_d, done_d, err_d, byte_d};
    end
  end

  assign lnk.r_sof = o_sof_q;
  assign lnk.r_bit_vld = o_vld_q;
  assign lnk.r_bit = o_bit_q;
  assign lnk.r_eof = o_eof_q;
  assign req_ready = (st_q == R_IDLE);
  assign rsp_vld = vld_q;
  assign rsp_byte = byte_q;
  assign rsp_done = done_q;
  assign rsp_err = err_q;
  assign rsp_family_ok = fam_q;
endmodule : ctfm_reader
`default_nettype wire

// >>> ctfm_link_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ctfm_link_sva (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // reader to tag
  input wire logic r_sof,
  input wire logic r_bit_vld,
  input wire logic r_bit,
  input wire logic r_eof,
  // tag to reader
  input wire logic t_sof,
  input wire logic t_bit_vld,
  input wire logic t_bit,
  input wire logic t_eof
);
  ////////////////////////////////////////////////////////////////
  // bit position and running parity in the tag frame
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic par_q;
  logic par_d;
  logic tx_q;
  logic tx_d;
  logic got_q;
  logic got_d;
  always_comb begin
    cnt_d = cnt_q;
    par_d = par_q;
    tx_d = tx_q;
    got_d = got_q;
    if (t_sof) begin
      cnt_d = 4'h0;
      par_d = 1'b0;
      tx_d = 1'b1;
      got_d = 1'b0;
    end else if (t_bit_vld) begin
      cnt_d = (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      par_d = (cnt_q == 4'h8) ? 1'b0 : par_q ^ t_bit;
      got_d = got_q | (cnt_q == 4'h8);
    end
    if (t_eof) begin
      tx_d = 1'b0;
    end
    if (!resetn) begin
      cnt_d = 4'h0;
      par_d = 1'b0;
      tx_d = 1'b0;
      got_d = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    cnt_q <= cnt_d;
    par_q <= par_d;
    tx_q <= tx_d;
    got_q <= got_d;
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_short;
    r_bit_vld [*7] ##1 r_eof;
  endsequence
  sequence s_oper;
    r_bit_vld [*8] ##1 r_eof;
  endsequence
  sequence s_first_byte;
    t_bit_vld [*8] ##1 t_bit_vld;
  endsequence
  chk_rx_frame_len: assert property (
    r_sof |=> s_short or s_oper) else $error("frame to tag has a bad bit count");
  chk_answer_delay: assert property (
    t_sof |-> $past(r_eof, 2)) else $error("answer start not two cycles after frame end");
  chk_first_byte: assert property (
    t_sof |=> s_first_byte) else $error("answer does not open with a whole byte");
  chk_bits_contig: assert property (
    t_bit_vld && cnt_q != 4'h8 |=> t_bit_vld) else $error("gap inside answer byte");
  chk_odd_parity: assert property (
    t_bit_vld && cnt_q == 4'h8 |-> par_q ^ t_bit) else $error("answer parity not odd");
  chk_par_next: assert property (
    t_bit_vld && cnt_q == 4'h8 |=> t_bit_vld || t_eof) else $error("gap after parity bit");
  chk_eof_place: assert property (
    t_eof |-> $past(t_bit_vld) && cnt_q == 4'h0 && got_q) else $error("answer end misplaced");
  chk_half_duplex: assert property (
    r_sof |-> !tx_q) else $error("reader frame during answer");
endmodule : ctfm_link_sva
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [55:0] UID = 56'h66554433221100;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic [6:0] req_code = 7'h00;
  logic [7:0] req_add = 8'h00;
  logic [7:0] req_dat = 8'h00;
  logic [31:0] req_uid = 32'h0;
  logic req_ready, rsp_vld, rsp_done, rsp_err, rsp_family_ok;
  logic [7:0] rsp_byte;
  logic tag_ready, cmd_fail, cmd_done;
  logic fail_seen = 1'b0;
  logic done_seen = 1'b0;
  logic [7:0] cap = 8'h00;
  logic [3:0] cap_n = 4'h8;
  logic [7:0] q[$];
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // code, address, data, expected data in answer
  logic [31:0] wt [12] = '{
    {1'b0, ctfm_pkg::CMD_WRE, 8'h08, 8'ha5, 8'ha5},
    {1'b0, ctfm_pkg::CMD_READ, 8'h08, 8'h00, 8'ha5},
    {1'b0, ctfm_pkg::CMD_WRNE, 8'h08, 8'h5a, 8'hff},
    {1'b0, ctfm_pkg::CMD_WRE, 8'h01, 8'hff, 8'h11},
    {1'b0, ctfm_pkg::CMD_READ, 8'h01, 8'h00, 8'h11},
    {1'b0, ctfm_pkg::CMD_WRE, 8'h72, 8'h0f, 8'h0f},
    {1'b0, ctfm_pkg::CMD_WRE, 8'h72, 8'hf0, 8'hff},
    {1'b0, ctfm_pkg::CMD_WRE, 8'h72, 8'h00, 8'hff},
    {1'b0, ctfm_pkg::CMD_WRNE, 8'h70, 8'h02, 8'h02},
    {1'b0, ctfm_pkg::CMD_WRE, 8'h09, 8'h33, 8'h00},
    {1'b0, ctfm_pkg::CMD_WRE, 8'h10, 8'h33, 8'h33},
    {1'b0, ctfm_pkg::CMD_WRE, 8'h68, 8'h77, 8'h00}};
  ctfm_link_if lnk();
  ctfm_tag #(.UID(UID), .HDR_RSV(8'hc3)) u_ctfm_tag (.clk(clk), .resetn(resetn),
    .lnk(lnk.tag_end), .tag_ready(tag_ready), .cmd_done(cmd_done), .cmd_fail(cmd_fail));
  ctfm_reader u_ctfm_reader (.clk(clk), .resetn(resetn), .lnk(lnk.reader_end),
    .req_valid(req_valid), .req_ready(req_ready), .req_code(req_code), .req_add(req_add),
    .req_dat(req_dat), .req_uid(req_uid), .rsp_vld(rsp_vld), .rsp_byte(rsp_byte),
    .rsp_done(rsp_done), .rsp_err(rsp_err), .rsp_family_ok(rsp_family_ok));
  ctfm_link_sva u_ctfm_link_sva (.clk(clk), .resetn(resetn), .r_sof(lnk.r_sof),
    .r_bit_vld(lnk.r_bit_vld), .r_bit(lnk.r_bit), .r_eof(lnk.r_eof), .t_sof(lnk.t_sof),
    .t_bit_vld(lnk.t_bit_vld), .t_bit(lnk.t_bit), .t_eof(lnk.t_eof));
  ////////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  // first answer byte off the wire, cycle ceiling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (lnk.t_sof === 1'b1) begin
      cap_n <= 4'h0;
    end else if (lnk.t_bit_vld === 1'b1 && cap_n < 4'h8) begin
      cap[cap_n[2:0]] <= lnk.t_bit;
      cap_n <= cap_n + 4'h1;
    end
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask : cmp1
  // one request, answer bytes gathered into q
  task automatic run(input logic [6:0] c, input logic [7:0] a, input logic [7:0] d,
    input logic [31:0] u);
    q = {};
    fail_seen = 1'b0;
    done_seen = 1'b0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_code <= c;
    req_add <= a;
    req_dat <= d;
    req_uid <= u;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk);
      if (cmd_fail === 1'b1) fail_seen = 1'b1;
      if (cmd_done === 1'b1) done_seen = 1'b1;
      if (rsp_vld === 1'b1) q.push_back(rsp_byte);
      if (rsp_done === 1'b1) break;
    end
  endtask : run
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    cmp1(tag_ready, 1'b0);
    run(ctfm_pkg::CMD_RID, 8'h00, 8'h00, 32'h0);
    cmp1(rsp_err, 1'b1);
    run(ctfm_pkg::CMD_REQA, 8'h00, 8'h00, 32'h0);
    cmp8(8'(q.size()), 8'h02);
    cmp1(tag_ready, 1'b1);
    cmp1(done_seen, 1'b1);
    cmp1(rsp_family_ok, 1'b0);
    run(ctfm_pkg::CMD_RID, 8'h00, 8'h00, 32'h0);
    cmp8(8'(q.size()), 8'h08);
    cmp8(q[0], ctfm_pkg::HDR_ID_DEF);
    cmp8(cap, ctfm_pkg::HDR_ID_DEF);
    for (int i = 0; i < 4; i++) cmp8(q[2 + i], UID[8 * i +: 8]);
    cmp1(rsp_family_ok, 1'b1);
    cmp1(rsp_err, 1'b0);
    foreach (wt[i]) begin
      run(wt[i][30:24], wt[i][23:16], wt[i][15:8], UID[31:0]);
      cmp8(q[0], wt[i][23:16]);
      cmp8(q[1], wt[i][7:0]);
      cmp8(cap, wt[i][23:16]);
    end
    run(ctfm_pkg::CMD_READ, 8'h08, 8'h00, ~UID[31:0]);
    cmp1(fail_seen, 1'b1);
    cmp1(done_seen, 1'b0);
    cmp1(rsp_err, 1'b1);
    cmp1(tag_ready, 1'b1);
    run(ctfm_pkg::CMD_READ_ALL_CMD, 8'h00, 8'h00, UID[31:0]);
    cmp8(8'(q.size()), 8'h7c);
    cmp8(q[0], ctfm_pkg::HDR_ID_DEF);
    cmp8(q[3], UID[15:8]);
    cmp8(q[10], 8'hff);
    cmp8(q[114], 8'h02);
    cmp8(q[116], 8'hff);
    cmp1(rsp_family_ok, 1'b1);
    cmp1(rsp_err, 1'b0);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
